// ===== design/drs_cfg.svh
`ifndef DRS_CFG_SVH
`define DRS_CFG_SVH

// Clock rate in kHz (20 MHz)
`define DRS_CLK_KHZ       20000
// Hold interval, nominal, in ms
`define DRS_HOLD_MS       350
// Hold interval in cycles
`define DRS_HOLD_CYC      (`DRS_HOLD_MS * `DRS_CLK_KHZ)
// Manual reset stable-low time, in ms
`define DRS_PB_MS         2
// Debounce interval in cycles: 1 ms, well inside the 2 ms limits
`define DRS_DEB_CYC       (`DRS_PB_MS * `DRS_CLK_KHZ / 2)
// Glitch filter on power-fail, in ns
`define DRS_GLITCH_NS     2000
// Glitch filter in cycles (50 ns period)
`define DRS_GLITCH_CYC    (`DRS_GLITCH_NS * `DRS_CLK_KHZ / 1000000)
// Tolerance window codes, per rail
`define DRS_TOL_5V_WIDE   8'h0A
`define DRS_TOL_5V_NARROW 8'h05
`define DRS_TOL_3V_WIDE   8'h14
`define DRS_TOL_3V_NARROW 8'h0A

`endif

// ===== design/drs_pkg.sv
package drs_pkg;

    // Per-rail state
    typedef enum logic [1:0] {
        DRS_ST_FAULT = 2'b00,
        DRS_ST_HOLD  = 2'b01,
        DRS_ST_RUN   = 2'b10
    } drs_state_e;

    // Per-rail tolerance window request to the analog comparator
    typedef struct packed {
        logic [7:0] pct_5v;
        logic [7:0] pct_3v;
    } drs_tol_s;

endpackage

// ===== design/drs_supervisor.sv
`timescale 1ns/1ps
`include "drs_cfg.svh"
// Notes on behaviour
// R1: Rail fail drives that rail's reset active.
// R2: Hold reset about 350 ms after fail clears.
// R3: Power-up holds both resets until rails good.
// R4: Outside holds manual input low 2 ms.
// R5: Manual low forces both; then hold interval.
// R6: Manual input debounced into one event.
// R7: 5 V strap selects 10% or 5%.
// R8: 3.3 V strap selects 20% or 10%.
// R9: Stable-low manual asserts resets within 2 ms.
// R10: Power-fail dips under 2 us ignored.
// R11: New cause restarts the hold interval.
// R12: Output polarity is a build parameter.
module drs_supervisor #(
    parameter int unsigned HOLD_CYC    = `DRS_HOLD_CYC,    // Hold length, shortenable
    parameter int unsigned DEB_CYC     = `DRS_DEB_CYC,     // Debounce length
    parameter int unsigned GLITCH_CYC  = `DRS_GLITCH_CYC,  // Power-fail filter length
    parameter bit          ACTIVE_HIGH = 1'b0              // Output polarity
) (
    input  wire logic       sys_clk,          // 20 MHz timebase
    input  wire logic       srst,             // Synchronous reset, high
    input  wire logic [1:0] power_fail,       // Comparator fail, [0]=5 V, [1]=3.3 V
    input  wire logic [1:0] tolerance_select, // Straps, 1=tied to rail input
    input  wire logic       manual_reset_n,   // Pushbutton, low requests reset
    output drs_pkg::drs_tol_s tol_window,     // Window percent to comparators
    output logic            rst_5v,           // 5 V rail reset, polarity per parameter
    output logic            rst_3v            // 3.3 V rail reset, polarity per parameter
);

    localparam int unsigned CW = $clog2(HOLD_CYC + 1);
    localparam int unsigned DW = $clog2(DEB_CYC + 1);
    localparam int unsigned GW = $clog2(GLITCH_CYC + 2);
    // Counter widths follow the parameters
    // Shortened counts in simulation then cost no extra flops
    // A full hold at 20 MHz needs 23 bits, so it can never wrap
    // Glitch counter sized one past its limit for the compare
    // Debounce counter sized to hold DEB_CYC, one past its top count DEB_CYC - 1

    // Timing summary, in clock cycles of sys_clk
    // Pin to first agreed sample: three flops, about three cycles
    // Agreed fail to filtered fail: GLITCH_CYC + 1 cycles
    // Filtered cause to state change: one cycle
    // State change to output pin: one cycle, outputs are registered
    // Cause clear to release: about HOLD_CYC + 6 cycles
    // Trade-off: registered outputs add a cycle but never glitch

    // Three-stage pin synchronisers
    logic [2:0] pf_sync_q [2];
    logic [2:0] pb_sync_q;
    logic [2:0] tol_sync_q [2];
    // Filtered fail levels
    logic [1:0] fail_q;
    // Debounced manual reset level, high while pressed
    logic       pb_q;
    logic [DW-1:0] pb_cnt_q;
    // Per-rail state and counters
    drs_pkg::drs_state_e st_q [2];
    logic [CW-1:0] hold_q [2];
    // Resets active internally
    logic [1:0] act;
    // Strap capture
    logic [1:0] tol_q;

    // Manual synchroniser and debounce
    // Counter restarts whenever the two late stages disagree
    // Only a level held for the whole window changes pb_q
    // Press and release both pass the same filter
    // A bouncing switch therefore yields one press, one release
    // Limitation: presses shorter than DEB_CYC are dropped
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pb_sync_q <= 3'h7;
            pb_cnt_q  <= '0;
            pb_q      <= 1'b0;
        end else begin
            pb_sync_q <= {pb_sync_q[1:0], manual_reset_n};
            // Only agreed samples count; stage 0 feeds stage 1 only
            if (pb_sync_q[1] != pb_sync_q[2]) begin
                pb_cnt_q <= '0;
            end else if ((!pb_sync_q[2]) == pb_q) begin
                // Level matches state, nothing pending
                pb_cnt_q <= '0;
            end else if (pb_cnt_q >= DW'(DEB_CYC - 1)) begin
                // Stable for whole debounce time: one event, bounce absorbed
                pb_q     <= !pb_sync_q[2];  // see R6, R9
                pb_cnt_q <= '0;
            end else begin
                pb_cnt_q <= pb_cnt_q + DW'(1);
            end
        end
    end

    // One copy of filter, strap capture and state per rail
    // Index 0 is the 5 V rail, index 1 the 3.3 V rail
    // Manual press reaches both copies through pb_q
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_rail
            logic [GW-1:0] gl_cnt_q;  // Fail persistence counter

            // Fail synchroniser and glitch filter
            // Starts failed, so power-up waits for a clean low
            // Clear is taken at once; only the set is delayed
            // Hazard: a slow set would leave a real dip unreset
            // Counter holds while stages disagree, no restart
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    pf_sync_q[g] <= 3'h7;
                    gl_cnt_q     <= '0;
                    fail_q[g]    <= 1'b1;
                end else begin
                    pf_sync_q[g] <= {pf_sync_q[g][1:0], power_fail[g]};
                    if (pf_sync_q[g][1] && pf_sync_q[g][2]) begin
                        // Fail must persist past 2 us before it counts
                        if (gl_cnt_q >= GW'(GLITCH_CYC)) begin
                            fail_q[g] <= 1'b1;  // see R10
                        end else begin
                            gl_cnt_q <= gl_cnt_q + GW'(1);
                        end
                    end else if (!pf_sync_q[g][1] && !pf_sync_q[g][2]) begin
                        gl_cnt_q  <= '0;
                        fail_q[g] <= 1'b0;
                    end
                end
            end

            // Strap synchroniser, read as a level
            // Straps are fixed in use; syncing guards against
            // a metastable first sample after power-up
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    tol_sync_q[g] <= 3'h0;
                    tol_q[g]      <= 1'b0;
                end else begin
                    tol_sync_q[g] <= {tol_sync_q[g][1:0], tolerance_select[g]};
                    if (tol_sync_q[g][1] == tol_sync_q[g][2]) begin
                        tol_q[g] <= tol_sync_q[g][2];
                    end
                end
            end

            // Rail state: fault, hold, run
            // Fault: cause present, counter parked at zero
            // Hold: cause gone, counter runs to HOLD_CYC - 1
            // Run: reset released until the next cause
            // Any cause in hold goes back to fault, so the
            // full interval always follows the last cause
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    // Power-up starts in fault so both resets are active
                    st_q[g]   <= drs_pkg::DRS_ST_FAULT;  // see R3
                    hold_q[g] <= '0;
                end else begin
                    case (st_q[g])
                        drs_pkg::DRS_ST_FAULT: begin
                            hold_q[g] <= '0;
                            if (!fail_q[g] && !pb_q) begin
                                st_q[g] <= drs_pkg::DRS_ST_HOLD;  // see R2, R3
                            end
                        end
                        drs_pkg::DRS_ST_HOLD: begin
                            if (fail_q[g] || pb_q) begin
                                // New cause restarts the interval
                                st_q[g] <= drs_pkg::DRS_ST_FAULT;  // see R11
                            end else if (hold_q[g] >= CW'(HOLD_CYC - 1)) begin
                                st_q[g] <= drs_pkg::DRS_ST_RUN;  // see R2
                            end else begin
                                hold_q[g] <= hold_q[g] + CW'(1);
                            end
                        end
                        drs_pkg::DRS_ST_RUN: begin
                            hold_q[g] <= '0;
                            // Fail hits own rail, manual hits both
                            if (fail_q[g] || pb_q) begin
                                st_q[g] <= drs_pkg::DRS_ST_FAULT;  // see R1, R5
                            end
                        end
                        default: begin
                            st_q[g] <= drs_pkg::DRS_ST_FAULT;
                        end
                    endcase
                end
            end

            assign act[g] = (st_q[g] != drs_pkg::DRS_ST_RUN);
        end
    endgenerate

    // Registered outputs, polarity selectable
    // Reset value is the active level, so the system
    // sees reset from the very first edge of srst
    // Same timing in both polarities, only the level differs
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rst_5v <= ACTIVE_HIGH;
            rst_3v <= ACTIVE_HIGH;
        end else begin
            rst_5v <= act[0] ~^ ACTIVE_HIGH;  // see R12
            rst_3v <= act[1] ~^ ACTIVE_HIGH;  // see R12
        end
    end

    // Tolerance window to comparators, from straps
    // Codes are percent values, binary coded
    // Narrow window after reset: the stricter check is safe
    // Limitation: the thresholds themselves are analog
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tol_window <= '{pct_5v: `DRS_TOL_5V_NARROW, pct_3v: `DRS_TOL_3V_NARROW};
        end else begin
            tol_window.pct_5v <= tol_q[0] ? `DRS_TOL_5V_WIDE : `DRS_TOL_5V_NARROW;  // see R7
            tol_window.pct_3v <= tol_q[1] ? `DRS_TOL_3V_WIDE : `DRS_TOL_3V_NARROW;  // see R8
        end
    end

endmodule

// ===== testbench/drs_supervisor_sva.sv
`timescale 1ns/1ps
// Ties each reset output to its causes at the inputs
module drs_supervisor_sva #(
    parameter int unsigned HOLD_CYC    = 50,
    parameter int unsigned DEB_CYC     = 8,
    parameter int unsigned GLITCH_CYC  = 4,
    parameter bit          ACTIVE_HIGH = 1'b0
) (
    input wire logic              sys_clk,
    input wire logic              srst,
    input wire logic [1:0]        power_fail,
    input wire logic [1:0]        tolerance_select,
    input wire logic              manual_reset_n,
    input wire drs_pkg::drs_tol_s tol_window,
    input wire logic              rst_5v,
    input wire logic              rst_3v
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    wire a5 = (rst_5v == ACTIVE_HIGH); // Active in either polarity
    wire a3 = (rst_3v == ACTIVE_HIGH);
    // Cycles since the last cause per rail; short glitches also clear it
    logic [31:0] q5_q;
    logic [31:0] q3_q;
    always_ff @(posedge sys_clk) begin
        q5_q <= (srst || power_fail[0] || !manual_reset_n) ? 32'h0 : q5_q + {31'h0, q5_q < 32'h3E7};
        q3_q <= (srst || power_fail[1] || !manual_reset_n) ? 32'h0 : q3_q + {31'h0, q3_q < 32'h3E7};
    end
    a_tol_5v_code: assert property ($stable(tolerance_select)[*6] |->
        tol_window.pct_5v == (tolerance_select[0] ? 8'h0A : 8'h05)) else $error("5 V window");
    a_tol_3v_code: assert property ($stable(tolerance_select)[*6] |->
        tol_window.pct_3v == (tolerance_select[1] ? 8'h14 : 8'h0A)) else $error("3 V window");
    a_fail_5v_rst: assert property (power_fail[0][*8] |-> ##[0:12] a5)
        else $error("5 V fail gave no reset");
    a_fail_3v_rst: assert property (power_fail[1][*8] |-> ##[0:12] a3)
        else $error("3 V fail gave no reset");
    a_hold_min_5v: assert property ($fell(a5) |-> q5_q >= HOLD_CYC)
        else $error("5 V reset released early");
    a_hold_min_3v: assert property ($fell(a3) |-> q3_q >= HOLD_CYC)
        else $error("3 V reset released early");
    a_hold_max_5v: assert property (q5_q >= HOLD_CYC + DEB_CYC + 12 |-> !a5)
        else $error("5 V reset held too long");
    a_hold_max_3v: assert property (q3_q >= HOLD_CYC + DEB_CYC + 12 |-> !a3)
        else $error("3 V reset held too long");
    a_manual_both: assert property (!manual_reset_n[*8] ##1 !manual_reset_n[*8]
        |-> ##[0:12] (a5 && a3)) else $error("manual press missed");
    c_rel_5v: cover property ($fell(a5));
    c_rel_3v: cover property ($fell(a3));
    c_one_rail: cover property (a5 && !a3);
endmodule
bind drs_supervisor drs_supervisor_sva #(.HOLD_CYC(HOLD_CYC), .DEB_CYC(DEB_CYC),
    .GLITCH_CYC(GLITCH_CYC), .ACTIVE_HIGH(ACTIVE_HIGH)) u_sva (.sys_clk(sys_clk),
    .srst(srst), .power_fail(power_fail), .tolerance_select(tolerance_select),
    .manual_reset_n(manual_reset_n), .tol_window(tol_window), .rst_5v(rst_5v), .rst_3v(rst_3v));

// ===== testbench/drs_host_model.sv
`timescale 1ns/1ps
// Processor side: reads reset lines, counts each release as one boot
module drs_host_model #(
    parameter bit ACTIVE_HIGH = 1'b0
) (
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       rst_5v,
    input  wire logic       rst_3v,
    output logic            in_rst_5v,
    output logic            in_rst_3v,
    output logic [7:0]      boots_5v,
    output logic [7:0]      boots_3v
);
    assign in_rst_5v = (rst_5v == ACTIVE_HIGH);
    assign in_rst_3v = (rst_3v == ACTIVE_HIGH);
    logic p5_q; // Previous reset state
    logic p3_q;
    // A bouncy reset would show up here as extra boots
    always_ff @(posedge sys_clk) begin
        p5_q <= in_rst_5v;
        p3_q <= in_rst_3v;
        boots_5v <= srst ? 8'h00 : boots_5v + {7'h0, p5_q && !in_rst_5v};
        boots_3v <= srst ? 8'h00 : boots_3v + {7'h0, p3_q && !in_rst_3v};
    end
endmodule

// ===== testbench/tb_drs_supervisor.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_drs_supervisor;
    localparam int unsigned HOLD = 50; // Shortened hold
    logic sys_clk = 1'b0, srst = 1'b1, manual_reset_n = 1'b1, i5, i3;
    logic [1:0] power_fail = 2'h0, tolerance_select = 2'h0;
    logic rst_5v, rst_3v;
    logic [7:0] b5, b3, bb, bb3;
    drs_pkg::drs_tol_s tol_window;
    int n_errors = 0, num_checks = 0, cyc_n = 0;
    logic [31:0] seed = 32'hE8F912DC;
    always #25 sys_clk = ~sys_clk;
    drs_supervisor #(.HOLD_CYC(HOLD), .DEB_CYC(8), .GLITCH_CYC(4), .ACTIVE_HIGH(1'b0)) dut (
        .sys_clk(sys_clk), .srst(srst), .power_fail(power_fail),
        .tolerance_select(tolerance_select), .manual_reset_n(manual_reset_n),
        .tol_window(tol_window), .rst_5v(rst_5v), .rst_3v(rst_3v));
    drs_host_model #(.ACTIVE_HIGH(1'b0)) host (.sys_clk(sys_clk), .srst(srst), .rst_5v(rst_5v),
        .rst_3v(rst_3v), .in_rst_5v(i5), .in_rst_3v(i3), .boots_5v(b5), .boots_3v(b3));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] exp_win(input logic [1:0] s); // Window codes per strap
        return {s[0] ? 8'h0A : 8'h05, s[1] ? 8'h14 : 8'h0A};
    endfunction
    task automatic cyc(input int n); // Inputs move 5 ns after the edge
        repeat (n) @(posedge sys_clk);
        #5;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Fault, short clear, second fault inside the hold, then timed release
    task automatic fault(input int r);
        power_fail[r] = 1'b1;
        cyc(20);
        `CHK("own rst", 1'b1, r ? i3 : i5)
        `CHK("other rst", 1'b0, r ? i5 : i3)
        power_fail[r] = 1'b0;
        cyc(10);
        power_fail[r] = 1'b1;
        cyc(20);
        power_fail[r] = 1'b0;
        cyc(HOLD - 5);
        `CHK("restart", 1'b1, r ? i3 : i5)
        cyc(30);
        `CHK("release", 1'b0, r ? i3 : i5)
        $display("fault test rail %0d done", r);
    endtask
    always @(posedge sys_clk) begin // Hang guard
        cyc_n++;
        if (cyc_n == 4000) begin
            n_errors++;
            $display("MISMATCH timeout exp done got hang");
            print_verdict();
        end
    end
    initial begin
        tolerance_select = 2'(rnd());
        cyc(4);
        srst = 1'b0;
        cyc(HOLD - 5);
        `CHK("powerup", 2'h3, {i5, i3})
        cyc(30);
        `CHK("powerup rel", 2'h0, {i5, i3})
        $display("powerup test done");
        for (int t = 0; t < 4; t++) begin
            tolerance_select = t[1:0];
            cyc(8);
            `CHK("window", exp_win(t[1:0]), tol_window)
        end
        $display("window test done");
        fault(0);
        fault(1);
        power_fail = 2'h3;
        cyc(3);
        power_fail = 2'h0;
        cyc(20);
        `CHK("glitch", 2'h0, {i5, i3})
        $display("glitch test done");
        bb = b5;
        bb3 = b3;
        repeat (6) begin // Switch bounce, each piece short of the debounce
            manual_reset_n = ~manual_reset_n;
            cyc(1 + int'(rnd() % 3));
        end
        manual_reset_n = 1'b0;
        cyc(20);
        `CHK("manual", 2'h3, {i5, i3})
        cyc(10);
        manual_reset_n = 1'b1;
        cyc(HOLD);
        `CHK("manual hold", 2'h3, {i5, i3})
        cyc(40);
        `CHK("one boot", bb + 8'h01, b5)
        `CHK("one boot 3v", bb3 + 8'h01, b3)
        $display("manual test done");
        print_verdict();
    end
endmodule
